//--- verilog/pth_defines.svh
// register offsets, field positions and reset values of the period timer
`ifndef PTH_DEFINES_SVH
`define PTH_DEFINES_SVH

// register offsets on the plain register port
`define PTH_OFS_COUNTER 3'h0
`define PTH_OFS_PERIOD 3'h1
`define PTH_OFS_CONTROL 3'h2
`define PTH_OFS_CONTROL2 3'h3
`define PTH_OFS_HLT 3'h4
`define PTH_OFS_RSTSEL 3'h5

// field positions
`define PTH_CTRL_RUN_BIT 7
`define PTH_CTRL_PRE_MSB 6
`define PTH_CTRL_PRE_LSB 4
`define PTH_POST_MSB 4
`define PTH_MODE_MSB 4
`define PTH_RSTSEL_MSB 2

// reset values
`define PTH_RST_COUNTER 8'h00
`define PTH_RST_PERIOD 8'hff
`define PTH_RST_FIELD5 5'h00
`define PTH_RST_PRE 3'h0
`define PTH_RST_SEL 3'h0
`define PTH_WRAP_VALUE 8'h00

`endif

//--- verilog/pth_pkg.sv
// types and helpers shared by the period timer files
package pth_pkg;

    // mode class, upper two bits of the mode field
    typedef enum logic [1:0] {
        PTH_CLS_FREE = 2'h0,
        PTH_CLS_ONESHOT = 2'h1,
        PTH_CLS_MONO = 2'h2,
        PTH_CLS_RSVD = 2'h3
    } pth_class_e;

    // start/stop/reset option, lower three bits of the mode field
    typedef enum logic [2:0] {
        PTH_OPT_SW = 3'h0,
        PTH_OPT_GATE_HI = 3'h1,
        PTH_OPT_GATE_LO = 3'h2,
        PTH_OPT_EDGE_RISE = 3'h3,
        PTH_OPT_EDGE_FALL = 3'h4,
        PTH_OPT_EDGE_ANY = 3'h5,
        PTH_OPT_LEVEL_HI = 3'h6,
        PTH_OPT_LEVEL_LO = 3'h7
    } pth_opt_e;

    // timer sequencing state, gray along idle-run-done
    typedef enum logic [1:0] {
        PTH_ST_IDLE = 2'h0,
        PTH_ST_RUN = 2'h1,
        PTH_ST_DONE = 2'h3
    } pth_state_e;

    // terminal count of the prescaler for a divide of 2**sel
    function automatic logic [6:0] pth_pre_mask(input logic [2:0] sel);
        pth_pre_mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
    endfunction

endpackage

//--- verilog/pth_prescaler.sv
// programmable prescaler producing the counter clock tick
`timescale 1ns/1ps
module pth_prescaler
    import pth_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // control
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic [2:0] sel_i,
    // tick out
    output logic tick_o
);

    logic [6:0] cnt_q;
    logic at_end;

    assign at_end = (cnt_q == pth_pre_mask(sel_i));

    // divide chain, cleared together with the postscaler
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i || (ce_i && clr_i))
        begin
            cnt_q <= 7'h00;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            tick_o <= en_i && at_end;
            if (en_i)
                cnt_q <= at_end ? 7'h00 : cnt_q + 7'h01;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking

    a_tick_clear: assert property (disable iff (sys_rst_i)
        (ce_i && clr_i) |=> !tick_o)
        else $error("prescaler tick survived a clear");

endmodule

//--- verilog/pth_ext_trig.sv
// external reset source selection, edge detection and debug freeze
`timescale 1ns/1ps
module pth_ext_trig (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // source
    input wire logic [7:0] src_i,
    input wire logic [2:0] sel_i,
    input wire logic freeze_i,
    // conditioned trigger
    output logic lvl_o,
    output logic rise_o,
    output logic fall_o
);

    logic prev_q;

    // while frozen the held level stands in for the source
    assign lvl_o = freeze_i ? prev_q : src_i[sel_i];
    assign rise_o = lvl_o && !prev_q;
    assign fall_o = !lvl_o && prev_q;

    // previous level for edge detection
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            prev_q <= 1'b0;
        else if (ce_i)
            prev_q <= lvl_o;
    end

    default clocking cb @(posedge ref_clk_i); endclocking

    a_freeze_quiet: assert property (disable iff (sys_rst_i)
        freeze_i |-> !rise_o && !fall_o)
        else $error("trigger edge seen during debug freeze");

endmodule

//--- verilog/pth_timer.sv
// period timer with prescaler, postscaler and hardware limit modes
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "pth_defines.svh"
module pth_timer
    import pth_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // external reset sources and debug
    input wire logic [7:0] ext_src_i,
    input wire logic dbg_freeze_i,
    // outputs to other peripherals
    output logic postscaled_match_pulse_o,
    output logic [7:0] period_counter_o,
    output logic counter_clock_o,
    output logic timer_run_o
);

    ////////////////////////////////////////////////////////////////////////
    // registers and decode

    logic [7:0] period_counter_q;
    logic [7:0] period_match_value_q;
    logic timer_run_bit_q;
    logic [2:0] pre_sel_q;
    logic [4:0] postscale_ratio_q;
    logic [4:0] mode_q;
    logic [2:0] reset_source_select_q;
    logic [4:0] post_cnt_q;
    logic pulse_q;
    logic [7:0] rdata_q;
    pth_state_e state_q;

    logic sw_cnt_wr;
    logic ctrl_wr;
    pth_class_e mode_cls;
    pth_opt_e mode_opt;
    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    logic ext_edge;
    logic lvl_hold;
    logic ext_clr;
    logic gate_ok;
    logic count_en;
    logic tick;
    logic cnt_adv;
    logic hit;
    logic period_end;
    logic post_hit;
    logic pre_clr;

    // write strokes that clear the scalers
    assign sw_cnt_wr = ce_i && reg_wr_i && (reg_addr_i == `PTH_OFS_COUNTER);
    assign ctrl_wr = ce_i && reg_wr_i && (reg_addr_i == `PTH_OFS_CONTROL);

    // mode field split, reserved class behaves as free running
    assign mode_cls = pth_class_e'(mode_q[4:3]);
    assign mode_opt = pth_opt_e'(mode_q[2:0]);

    ////////////////////////////////////////////////////////////////////////
    // external source conditioning

    pth_ext_trig u_trig (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .src_i(ext_src_i),
        .sel_i(reset_source_select_q),
        .freeze_i(dbg_freeze_i),
        .lvl_o(ext_lvl),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // edge and level reset events per option
    always_comb
    begin
        ext_edge = 1'b0;
        lvl_hold = 1'b0;
        gate_ok = 1'b1;
        unique case (mode_opt)
            PTH_OPT_SW: gate_ok = 1'b1;
            PTH_OPT_GATE_HI: gate_ok = ext_lvl;
            PTH_OPT_GATE_LO: gate_ok = !ext_lvl;
            PTH_OPT_EDGE_RISE: ext_edge = ext_rise;
            PTH_OPT_EDGE_FALL: ext_edge = ext_fall;
            PTH_OPT_EDGE_ANY: ext_edge = ext_rise || ext_fall;
            PTH_OPT_LEVEL_HI: lvl_hold = ext_lvl;
            PTH_OPT_LEVEL_LO: lvl_hold = !ext_lvl;
        endcase
    end

    // an edge counts only while the timer is enabled
    assign ext_clr = ce_i && timer_run_bit_q && (ext_edge || lvl_hold);

    ////////////////////////////////////////////////////////////////////////
    // prescaler and counting

    assign count_en = (state_q == PTH_ST_RUN) && gate_ok && !lvl_hold;
    assign pre_clr = sw_cnt_wr || ctrl_wr || ext_clr;

    pth_prescaler u_pre (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .clr_i(pre_clr),
        .en_i(count_en || pulse_q),
        .sel_i(pre_sel_q),
        .tick_o(tick)
    );

    assign cnt_adv = ce_i && tick && count_en && !sw_cnt_wr && !ctrl_wr && !ext_clr;
    assign hit = (period_counter_q == period_match_value_q);
    assign period_end = cnt_adv && hit;
    assign post_hit = period_end && (post_cnt_q == postscale_ratio_q);

    // period counter: software write, external clear, then tick
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            period_counter_q <= `PTH_RST_COUNTER;
        else if (sw_cnt_wr)
            period_counter_q <= reg_wdata_i;
        else if (ext_clr)
            period_counter_q <= `PTH_WRAP_VALUE;
        else if (period_end)
            period_counter_q <= `PTH_WRAP_VALUE;
        else if (cnt_adv)
            period_counter_q <= period_counter_q + 8'h01;
    end

    // postscaler count and one-tick-wide output pulse
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i || (ce_i && pre_clr))
        begin
            post_cnt_q <= 5'h00;
            pulse_q <= 1'b0;
        end
        else if (ce_i && tick)
        begin
            pulse_q <= post_hit;
            if (post_hit)
                post_cnt_q <= 5'h00;
            else if (period_end)
                post_cnt_q <= post_cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // run sequencing

    // idle until run bit, done after match in one-shot or monostable
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            state_q <= PTH_ST_IDLE;
        else if (ce_i)
        begin
            unique case (state_q)
                PTH_ST_IDLE:
                    if (timer_run_bit_q)
                        state_q <= PTH_ST_RUN;
                PTH_ST_RUN:
                    if (!timer_run_bit_q)
                        state_q <= PTH_ST_IDLE;
                    else if (period_end && (mode_cls == PTH_CLS_ONESHOT
                             || mode_cls == PTH_CLS_MONO))
                        state_q <= PTH_ST_DONE;
                PTH_ST_DONE:
                    if (!timer_run_bit_q || ctrl_wr)
                        state_q <= PTH_ST_IDLE;
                    else if (mode_cls == PTH_CLS_MONO && ext_clr)
                        state_q <= PTH_ST_RUN;
                default:
                    state_q <= PTH_ST_IDLE;
            endcase
        end
    end

    // run bit: software write wins over the one-shot clear
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            timer_run_bit_q <= 1'b0;
        else if (ctrl_wr)
            timer_run_bit_q <= reg_wdata_i[`PTH_CTRL_RUN_BIT];
        else if (ce_i && period_end && mode_cls == PTH_CLS_ONESHOT)
            timer_run_bit_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers and read port

    // software-written configuration
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            period_match_value_q <= `PTH_RST_PERIOD;
            pre_sel_q <= `PTH_RST_PRE;
            postscale_ratio_q <= `PTH_RST_FIELD5;
            mode_q <= `PTH_RST_FIELD5;
            reset_source_select_q <= `PTH_RST_SEL;
        end
        else if (ce_i && reg_wr_i)
        begin
            unique case (reg_addr_i)
                `PTH_OFS_PERIOD: period_match_value_q <= reg_wdata_i;
                `PTH_OFS_CONTROL:
                    pre_sel_q <= reg_wdata_i[`PTH_CTRL_PRE_MSB:`PTH_CTRL_PRE_LSB];
                `PTH_OFS_CONTROL2: postscale_ratio_q <= reg_wdata_i[`PTH_POST_MSB:0];
                `PTH_OFS_HLT: mode_q <= reg_wdata_i[`PTH_MODE_MSB:0];
                `PTH_OFS_RSTSEL:
                    reset_source_select_q <= reg_wdata_i[`PTH_RSTSEL_MSB:0];
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            rdata_q <= 8'h00;
        else if (ce_i)
        begin
            rdata_q <= 8'h00;
            if (reg_rd_i)
            begin
                unique case (reg_addr_i)
                    `PTH_OFS_COUNTER: rdata_q <= period_counter_q;
                    `PTH_OFS_PERIOD: rdata_q <= period_match_value_q;
                    `PTH_OFS_CONTROL:
                        rdata_q <= {timer_run_bit_q, pre_sel_q, 4'h0};
                    `PTH_OFS_CONTROL2: rdata_q <= {3'h0, postscale_ratio_q};
                    `PTH_OFS_HLT: rdata_q <= {3'h0, mode_q};
                    `PTH_OFS_RSTSEL: rdata_q <= {5'h00, reset_source_select_q};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o = rdata_q;
    assign postscaled_match_pulse_o = pulse_q;
    assign period_counter_o = period_counter_q;
    assign counter_clock_o = tick;
    assign timer_run_o = timer_run_bit_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk_i); endclocking

    sequence s_final_tick;
        period_end && mode_cls == PTH_CLS_ONESHOT && !ctrl_wr;
    endsequence

    sequence s_mono_end;
        period_end && mode_cls == PTH_CLS_MONO && !ctrl_wr;
    endsequence

    a_reset_values: assert property (
        sys_rst_i |=> period_counter_q == 8'h00 && period_match_value_q == 8'hff)
        else $error("reset values wrong");

    a_count_step: assert property (disable iff (sys_rst_i)
        cnt_adv && !hit |=> period_counter_q == $past(period_counter_q) + 8'h01)
        else $error("counter did not step");

    a_match_wrap: assert property (disable iff (sys_rst_i)
        period_end |=> period_counter_q == 8'h00)
        else $error("counter did not wrap on match");

    a_gate_hold: assert property (disable iff (sys_rst_i)
        ce_i && !gate_ok && !sw_cnt_wr && !ext_clr |=> $stable(period_counter_q))
        else $error("counter moved while gate closed");

    a_level_clear: assert property (disable iff (sys_rst_i)
        ext_clr && !sw_cnt_wr |=> period_counter_q == 8'h00)
        else $error("external reset did not clear counter");

    a_sw_write: assert property (disable iff (sys_rst_i)
        sw_cnt_wr |=> period_counter_o == $past(reg_wdata_i))
        else $error("counter write lost");

    a_ctrl_keeps: assert property (disable iff (sys_rst_i)
        ctrl_wr && !ext_clr |=> $stable(period_counter_q) && post_cnt_q == 5'h00)
        else $error("control write disturbed counter or kept postscaler");

    a_pulse_width: assert property (disable iff (sys_rst_i)
        pulse_q && !(ce_i && (tick || pre_clr)) |=> pulse_q)
        else $error("postscaled pulse ended before the next tick");

    a_oneshot_stop: assert property (disable iff (sys_rst_i)
        s_final_tick |=> !timer_run_bit_q ##1 state_q != PTH_ST_RUN)
        else $error("one-shot did not stop");

    a_mono_hold: assert property (disable iff (sys_rst_i)
        s_mono_end |=> timer_run_bit_q && state_q == PTH_ST_DONE)
        else $error("monostable did not park with run bit set");

    a_read_back: assert property (disable iff (sys_rst_i)
        ce_i && reg_rd_i && reg_addr_i == `PTH_OFS_PERIOD && !reg_wr_i
        |=> reg_rdata_o == $past(period_match_value_q))
        else $error("period read back wrong");

endmodule

//--- test/pth_src_model.sv
// far-side model: reset-source lines and postscaled pulse consumer
`timescale 1ns/1ps
module pth_src_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // requested level, line choice, pulse in
    input wire logic lvl_i,
    input wire logic [2:0] sel_i,
    input wire logic pulse_i,
    // source lines and pulse count
    output logic [7:0] ext_src_o,
    output logic [7:0] pulse_cnt_o
);
    logic line_q;
    logic noise_q;
    logic pulse_q;
    logic [3:0] gap_q;

    ////////////////////////////////////////////////////////////////////////////////
    // selected line moves only after six quiet timer clocks
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            line_q <= 1'b0;
            gap_q <= 4'h0;
        end
        else if (gap_q < 4'h6)
            gap_q <= gap_q + 4'h1;
        else if (lvl_i != line_q)
        begin
            line_q <= lvl_i;
            gap_q <= 4'h0;
        end
    end

    // unselected lines toggle each cycle so a wrong pick shows
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            noise_q <= 1'b0;
        else
            noise_q <= ~noise_q;
    end

    // counts rising edges of the postscaled pulse, as a trigger input would
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pulse_q <= 1'b0;
            pulse_cnt_o <= 8'h00;
        end
        else
        begin
            pulse_q <= pulse_i;
            if (pulse_i && !pulse_q)
                pulse_cnt_o <= pulse_cnt_o + 8'h01;
        end
    end

    assign ext_src_o = ({8{noise_q}} & ~(8'h01 << sel_i)) | (8'(line_q) << sel_i);
endmodule

//--- test/pth_timer_tb.sv
// self-checking bench for the period timer
`timescale 1ns/1ps
`include "pth_defines.svh"
module pth_timer_tb;
    typedef struct {logic [2:0] sel; logic [7:0] per; logic [4:0] ratio; int cyc; int wid;} pth_row_s;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic dbg_freeze_i = 1'b0;
    logic src_lvl = 1'b0;
    logic [2:0] src_sel = 3'h0;
    logic [7:0] reg_rdata_o, period_counter_o, ext_src_i, pulse_cnt;
    logic postscaled_match_pulse_o, counter_clock_o, timer_run_o;
    logic [7:0] v, v2;
    int num_errors = 0;
    int compares = 0;
    int w, c, k;
    pth_row_s rows [5] = '{'{3'h0, 8'h01, 5'h00, 2, 1}, '{3'h1, 8'h03, 5'h00, 8, 2},
        '{3'h0, 8'h04, 5'h02, 15, 1}, '{3'h2, 8'h02, 5'h01, 24, 4}, '{3'h3, 8'h02, 5'h00, 24, 8}};
    logic [7:0] rst_vals [7] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    ////////////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #50 ref_clk_i = ~ref_clk_i;

    pth_timer i_pth_timer (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ext_src_i(ext_src_i),
        .dbg_freeze_i(dbg_freeze_i), .postscaled_match_pulse_o(postscaled_match_pulse_o),
        .period_counter_o(period_counter_o), .counter_clock_o(counter_clock_o),
        .timer_run_o(timer_run_o));

    pth_src_model i_pth_src_model (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .lvl_i(src_lvl), .sel_i(src_sel), .pulse_i(postscaled_match_pulse_o),
        .ext_src_o(ext_src_i), .pulse_cnt_o(pulse_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic end_of_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic wait_pulse();
        int n;
        n = 0;
        while (postscaled_match_pulse_o !== 1'b1 && n < 3000)
        begin
            step(1);
            n++;
        end
        chk("pulse seen", {15'h0, postscaled_match_pulse_o}, 16'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        step(40000);
        num_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        step(1);
        // reset values, unmapped place, read-back
        foreach (rst_vals[i])
        begin
            rd(3'(i), v);
            chk("reset value", {8'h0, v}, {8'h0, rst_vals[i]});
        end
        wr(3'h6, 8'h55);
        rd(3'h6, v);
        chk("unmapped read", {8'h0, v}, 16'h0000);
        wr(`PTH_OFS_COUNTER, 8'h37);
        wr(`PTH_OFS_CONTROL, 8'h10);
        rd(`PTH_OFS_COUNTER, v);
        chk("counter after control write", {8'h0, v}, 16'h0037);
        wr(`PTH_OFS_PERIOD, 8'h5a);
        rd(`PTH_OFS_PERIOD, v);
        chk("period read-back", {8'h0, v}, 16'h005a);
        // free-running table: spacing, width, wrap, tick rate
        foreach (rows[i])
        begin
            wr(`PTH_OFS_CONTROL, 8'h00);
            wr(`PTH_OFS_COUNTER, 8'h00);
            wr(`PTH_OFS_PERIOD, rows[i].per);
            wr(`PTH_OFS_CONTROL2, {3'h0, rows[i].ratio});
            wr(`PTH_OFS_CONTROL, {1'b1, rows[i].sel, 4'h0});
            wait_pulse();
            w = 0;
            v = 8'h00;
            while (postscaled_match_pulse_o === 1'b1 && w < 300)
            begin
                step(1);
                w++;
            end
            c = w;
            while (postscaled_match_pulse_o !== 1'b1 && c < 3000)
            begin
                if (period_counter_o > v)
                    v = period_counter_o;
                step(1);
                c++;
            end
            chk("pulse width", 16'(w), 16'(rows[i].wid));
            chk("pulse spacing", 16'(c), 16'(rows[i].cyc));
            chk("highest count", {8'h0, v}, {8'h0, rows[i].per});
            k = 0;
            while (counter_clock_o !== 1'b1 && k < 20)
            begin
                step(1);
                k++;
            end
            step(1);
            k = 1;
            while (counter_clock_o !== 1'b1 && k < 20)
            begin
                step(1);
                k++;
            end
            chk("tick spacing", 16'(k), 16'(1 << rows[i].sel));
        end
        // one-shot: stops and clears run bit, restarts on software
        wr(`PTH_OFS_CONTROL, 8'h00);
        wr(`PTH_OFS_CONTROL2, 8'h00);
        wr(`PTH_OFS_HLT, 8'h08);
        wr(`PTH_OFS_PERIOD, 8'h03);
        wr(`PTH_OFS_CONTROL, 8'h80);
        wait_pulse();
        step(4);
        chk("run after one-shot", {15'h0, timer_run_o}, 16'h0);
        rd(`PTH_OFS_CONTROL, v);
        chk("control after one-shot", {8'h0, v}, 16'h0000);
        v2 = period_counter_o;
        step(20);
        rd(`PTH_OFS_COUNTER, v);
        chk("stopped counter", {8'h0, v}, {8'h0, v2});
        wr(`PTH_OFS_CONTROL, 8'h80);
        wait_pulse(); // restart
        // monostable, edge restart on line 2, freeze ignores it
        wr(`PTH_OFS_CONTROL, 8'h00);
        wr(`PTH_OFS_HLT, 8'h13);
        wr(`PTH_OFS_RSTSEL, 8'h02);
        src_sel <= 3'h2;
        wr(`PTH_OFS_CONTROL, 8'h80);
        wait_pulse();
        step(4);
        chk("run in monostable", {15'h0, timer_run_o}, 16'h1);
        v2 = pulse_cnt;
        dbg_freeze_i <= 1'b1;
        src_lvl <= 1'b1;
        step(20);
        src_lvl <= 1'b0;
        step(20);
        dbg_freeze_i <= 1'b0;
        step(20);
        chk("pulses under freeze", {8'h0, pulse_cnt}, {8'h0, v2});
        src_lvl <= 1'b1;
        wait_pulse();
        src_lvl <= 1'b0;
        // gate high mode: halt and resume
        wr(`PTH_OFS_CONTROL, 8'h00);
        wr(`PTH_OFS_HLT, 8'h01);
        wr(`PTH_OFS_PERIOD, 8'hff);
        wr(`PTH_OFS_COUNTER, 8'h00);
        step(10);
        wr(`PTH_OFS_CONTROL, 8'h80);
        step(20);
        chk("gate shut", {8'h0, period_counter_o}, 16'h0000);
        src_lvl <= 1'b1;
        step(20);
        src_lvl <= 1'b0;
        step(10);
        v2 = period_counter_o;
        chk("gate opened", {15'h0, v2 != 8'h00}, 16'h1);
        step(20);
        chk("gate held", {8'h0, period_counter_o}, {8'h0, v2});
        src_lvl <= 1'b1;
        step(20);
        chk("gate resumed", {15'h0, period_counter_o > v2}, 16'h1);
        // level-high reset mode
        wr(`PTH_OFS_CONTROL, 8'h00);
        wr(`PTH_OFS_HLT, 8'h06);
        src_lvl <= 1'b0;
        step(10);
        wr(`PTH_OFS_CONTROL, 8'h80);
        step(20);
        src_lvl <= 1'b1;
        step(12);
        chk("level reset", {8'h0, period_counter_o}, 16'h0000);
        src_lvl <= 1'b0;
        step(20);
        chk("after level", {15'h0, period_counter_o != 8'h00}, 16'h1);
        // level-low reset, then gate low
        wr(`PTH_OFS_HLT, 8'h07);
        step(12);
        chk("low level reset", {8'h0, period_counter_o}, 16'h0000);
        src_lvl <= 1'b1;
        step(20);
        chk("after low level", {15'h0, period_counter_o != 8'h00}, 16'h1);
        wr(`PTH_OFS_HLT, 8'h02);
        step(3);
        v2 = period_counter_o;
        step(20);
        chk("low gate held", {8'h0, period_counter_o}, {8'h0, v2});
        src_lvl <= 1'b0;
        step(20);
        chk("low gate open", {15'h0, period_counter_o > v2}, 16'h1);
        // clock enable low freezes the count
        ce_i <= 1'b0;
        v2 = period_counter_o;
        step(10);
        chk("frozen by enable", {8'h0, period_counter_o}, {8'h0, v2});
        ce_i <= 1'b1;
        step(5);
        chk("enable resumes", {15'h0, period_counter_o != v2}, 16'h1);
        // reset in mid-run
        sys_rst_i <= 1'b1;
        step(2);
        sys_rst_i <= 1'b0;
        step(1);
        chk("counter after reset", {8'h0, period_counter_o}, 16'h0000);
        chk("run after reset", {15'h0, timer_run_o}, 16'h0);
        rd(`PTH_OFS_PERIOD, v);
        chk("period after reset", {8'h0, v}, 16'h00ff);
        end_of_test();
    end
endmodule
